// [src/msf_filter.sv]
`timescale 1ns/1ps
module msf_filter
    import msf_pkg::*;
(
    input wire logic ref_clk, // 100 MHz
    input wire logic rst_n, // sync reset
    input wire logic req, // access request, one cycle
    input wire logic req_sec, // 1 = secure alias
    input wire logic req_wr, // 1 = write
    input wire logic [ADDR_W-1:0] req_addr, // byte offset
    input wire logic [DATA_W-1:0] req_wdata, // write data
    output logic rsp_valid, // answer pulse
    output logic rsp_err, // access refused
    output logic [DATA_W-1:0] rsp_rdata, // read data
    output logic [RES_W-1:0] pin_out, // mixed resource outputs
    output logic watch_irq // attribution differs from watch copy
);
    logic [2:0] cls;
    logic mapped;
    msf_class_dec u_dec (
        .addr(req_addr),
        .cls(cls),
        .mapped(mapped)
    );

    msf_state_e st_r, st_nxt;
    logic [DATA_W-1:0] ctrl_r, ctrl_nxt, key_r, key_nxt, cfg_r, cfg_nxt;
    logic [DATA_W-1:0] nvcmd_r, nvcmd_nxt, rdata_r, rdata_nxt;
    logic [RES_W-1:0] out_r, out_nxt, attr_r, attr_nxt, watch_r, watch_nxt;
    logic wien_r, wien_nxt, wflag_r, wflag_nxt, err_r, err_nxt, irq_r, irq_nxt;
    logic valid_r, valid_nxt;
    logic ok;
    logic [RES_W-1:0] ns_mask;

    always_comb begin
        st_nxt = st_r;
        ctrl_nxt = ctrl_r;
        key_nxt = key_r;
        cfg_nxt = cfg_r;
        nvcmd_nxt = nvcmd_r;
        out_nxt = out_r;
        attr_nxt = attr_r;
        watch_nxt = watch_r;
        wien_nxt = wien_r;
        wflag_nxt = wflag_r;
        err_nxt = 1'b0;
        rdata_nxt = READ_ZERO;
        ok = 1'b0;
        ns_mask = req_sec ? {RES_W{1'b1}} : attr_r;
        unique case (st_r)
            MSF_IDLE: begin
                if (req) begin
                    st_nxt = MSF_RESP;
                    unique case (cls)
                        CLS_RESOURCE_ATTRIBUTION: ok = mapped;
                        CLS_SEC: ok = mapped && req_sec;
                        CLS_WSEC: ok = req_sec || !req_wr;
                        CLS_MIX: ok = 1'b1;
                        CLS_WMIX: ok = req_sec || !req_wr || attr_r[NVM_WEN_BIT];
                        default: ok = 1'b0;
                    endcase
                    // refused: error, zero data, no state change
                    err_nxt = !ok;
                    if (ok && !req_wr) begin
                        unique case (req_addr)
                            OFS_CTRL: rdata_nxt = ctrl_r;
                            OFS_KEY: rdata_nxt = key_r;
                            OFS_CFG: rdata_nxt = cfg_r;
                            OFS_OUT: rdata_nxt = out_r & ns_mask;
                            OFS_NVCMD: rdata_nxt = nvcmd_r;
                            OFS_ATTR: rdata_nxt = attr_r;
                            OFS_WATCH: rdata_nxt = watch_r;
                            OFS_WIEN: rdata_nxt = {31'h0, wien_r};
                            OFS_WFLAG: rdata_nxt = {31'h0, wflag_r};
                            default: rdata_nxt = READ_ZERO;
                        endcase
                    end
                    if (ok && req_wr) begin
                        unique case (req_addr)
                            OFS_CTRL: ctrl_nxt = req_wdata;
                            OFS_KEY: key_nxt = req_wdata;
                            OFS_CFG: cfg_nxt = req_wdata;
                            OFS_OUT: out_nxt = (out_r & ~ns_mask) | (req_wdata & ns_mask);
                            OFS_NVCMD: nvcmd_nxt = req_wdata;
                            OFS_ATTR: attr_nxt = req_wdata;
                            OFS_WATCH: watch_nxt = req_wdata;
                            OFS_WIEN: wien_nxt = req_wdata[FLAG_BIT];
                            // write one to clear
                            OFS_WFLAG: if (req_wdata[FLAG_BIT]) wflag_nxt = 1'b0;
                            default: ;
                        endcase
                    end
                end
            end
            MSF_RESP: st_nxt = MSF_IDLE;
            default: st_nxt = MSF_IDLE;
        endcase
        // change detect; set wins over clear
        if (wien_r && (attr_r != watch_r))
            wflag_nxt = 1'b1;
        irq_nxt = wflag_nxt && wien_nxt;
        valid_nxt = (st_nxt == MSF_RESP);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= MSF_IDLE;
            ctrl_r <= RST_WORD;
            key_r <= RST_WORD;
            cfg_r <= RST_WORD;
            nvcmd_r <= RST_WORD;
            out_r <= RST_ATTR;
            attr_r <= RST_ATTR;
            watch_r <= RST_ATTR;
            wien_r <= 1'b0;
            wflag_r <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= READ_ZERO;
            irq_r <= 1'b0;
            valid_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ctrl_r <= ctrl_nxt;
            key_r <= key_nxt;
            cfg_r <= cfg_nxt;
            nvcmd_r <= nvcmd_nxt;
            out_r <= out_nxt;
            attr_r <= attr_nxt;
            watch_r <= watch_nxt;
            wien_r <= wien_nxt;
            wflag_r <= wflag_nxt;
            err_r <= err_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign rsp_valid = valid_r;
    assign rsp_err = err_r;
    assign rsp_rdata = rdata_r;
    assign pin_out = out_r;
    assign watch_irq = irq_r;

    property p_ns_key_refused;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_r == MSF_IDLE && req && !req_sec && req_addr == OFS_KEY)
            |=> (rsp_valid && rsp_err && rsp_rdata == READ_ZERO);
    endproperty
    a_ns_key_refused: assert property (p_ns_key_refused) else $error("ns key not refused");

    property p_ns_cfg_write_kept;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_r == MSF_IDLE && req && !req_sec && req_wr && req_addr == OFS_CFG)
            |=> (rsp_err && $stable(cfg_r));
    endproperty
    a_ns_cfg_write_kept: assert property (p_ns_cfg_write_kept) else $error("cfg changed");

    property p_open_ok;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_r == MSF_IDLE && req && req_addr == OFS_CTRL) |=> (rsp_valid && !rsp_err);
    endproperty
    a_open_ok: assert property (p_open_ok) else $error("open register refused");

    property p_sec_cfg_write;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_r == MSF_IDLE && req && req_sec && req_wr && req_addr == OFS_CFG)
            |=> (cfg_r == $past(req_wdata) && !rsp_err);
    endproperty
    a_sec_cfg_write: assert property (p_sec_cfg_write) else $error("secure cfg write lost");

    property p_mix_mask;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_r == MSF_IDLE && req && !req_sec && req_wr && req_addr == OFS_OUT)
            |=> ((out_r & ~$past(attr_r)) == ($past(out_r) & ~$past(attr_r)));
    endproperty
    a_mix_mask: assert property (p_mix_mask) else $error("secure bit changed");

    property p_nvm_auth;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_r == MSF_IDLE && req && !req_sec && req_wr && req_addr == OFS_NVCMD)
            |=> (rsp_err == !$past(attr_r[NVM_WEN_BIT]));
    endproperty
    a_nvm_auth: assert property (p_nvm_auth) else $error("nvm write auth wrong");

    property p_ns_attr_read;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_r == MSF_IDLE && req && !req_sec && !req_wr && req_addr == OFS_ATTR)
            |=> (rsp_valid && !rsp_err && rsp_rdata == $past(attr_r));
    endproperty
    a_ns_attr_read: assert property (p_ns_attr_read) else $error("attribution hidden");

    property p_watch_irq;
        @(posedge ref_clk) disable iff (!rst_n)
        (wien_r && attr_r != watch_r) |=> (watch_irq == wien_r);
    endproperty
    a_watch_irq: assert property (p_watch_irq) else $error("no watch interrupt");

    property p_refuse_no_attr;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_r == MSF_IDLE && req && !req_sec && req_wr && req_addr == OFS_ATTR)
            |=> ($stable(attr_r) && rsp_err);
    endproperty
    a_refuse_no_attr: assert property (p_refuse_no_attr) else $error("attr written ns");
endmodule : msf_filter

// [src/msf_pkg.sv]
package msf_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RES_W = 32;
    // register classes
    localparam logic [2:0] CLS_RESOURCE_ATTRIBUTION = 3'h0;
    localparam logic [2:0] CLS_SEC = 3'h1;
    localparam logic [2:0] CLS_WSEC = 3'h2;
    localparam logic [2:0] CLS_MIX = 3'h3;
    localparam logic [2:0] CLS_WMIX = 3'h4;
    // fixed register map of the filtered peripheral
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_KEY = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CFG = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OUT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_NVCMD = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_ATTR = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_WATCH = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_WIEN = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_WFLAG = 8'h20;
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [RES_W-1:0] RST_ATTR = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
    localparam int NVM_WEN_BIT = 31;
    localparam int FLAG_BIT = 0;
    typedef enum logic [1:0] {
        MSF_IDLE = 2'b01,
        MSF_RESP = 2'b10
    } msf_state_e;
endpackage : msf_pkg

// [src/msf_class_dec.sv]
`timescale 1ns/1ps
module msf_class_dec
    import msf_pkg::*;
(
    input wire logic [ADDR_W-1:0] addr, // byte offset
    output logic [2:0] cls, // security class
    output logic mapped // offset exists
);
    always_comb begin
        mapped = 1'b1;
        unique case (addr)
            OFS_CTRL: cls = CLS_RESOURCE_ATTRIBUTION;
            OFS_KEY: cls = CLS_SEC;
            OFS_CFG: cls = CLS_WSEC;
            OFS_OUT: cls = CLS_MIX;
            OFS_NVCMD: cls = CLS_WMIX;
            OFS_ATTR: cls = CLS_WSEC;
            OFS_WATCH: cls = CLS_RESOURCE_ATTRIBUTION;
            OFS_WIEN: cls = CLS_RESOURCE_ATTRIBUTION;
            OFS_WFLAG: cls = CLS_RESOURCE_ATTRIBUTION;
            default: begin
                cls = CLS_SEC;
                mapped = 1'b0;
            end
        endcase
    end
endmodule : msf_class_dec

// [tb/msf_bus_master.sv]
`timescale 1ns/1ps
module msf_bus_master
    import msf_pkg::*;
(
    input wire logic ref_clk, // bus clock
    output logic req, // request pulse
    output logic req_sec, // alias select
    output logic req_wr, // write strobe
    output logic [ADDR_W-1:0] req_addr, // byte offset
    output logic [DATA_W-1:0] req_wdata // write data
);
    initial begin
        req = 1'h0;
        req_sec = 1'h0;
        req_wr = 1'h0;
        req_addr = 8'h00;
        req_wdata = 32'h0;
    end
    // one request, then two idle cycles before the next; the answer is valid in the first idle cycle
    task automatic access(input logic s, input logic w, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        @(negedge ref_clk);
        req <= 1'h1;
        req_sec <= s;
        req_wr <= w;
        req_addr <= a;
        req_wdata <= d;
        @(negedge ref_clk);
        // released fields show garbage, not the last value
        req <= 1'h0;
        req_sec <= ~s;
        req_wr <= ~w;
        req_addr <= ~a;
        req_wdata <= ~d;
        @(negedge ref_clk);
    endtask : access
endmodule : msf_bus_master

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
    import msf_pkg::*;
    localparam logic N = 1'h0;
    localparam logic S = 1'h1;
    localparam logic R = 1'h0;
    localparam logic W = 1'h1;
    localparam logic [DATA_W-1:0] Z = 32'h0;
    logic ref_clk, rst_n, req, req_sec, req_wr, rsp_valid, rsp_err, watch_irq;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, lfsr, a, x, d;
    logic [RES_W-1:0] pin_out;
    logic [DATA_W:0] exp_q[$];
    int err_count = 0;
    int compares = 0;
    int cycles = 0;

    msf_filter dut(.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .req_sec(req_sec),
        .req_wr(req_wr), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
        .pin_out(pin_out), .watch_irq(watch_irq));
    msf_bus_master m(.ref_clk(ref_clk), .req(req), .req_sec(req_sec), .req_wr(req_wr),
        .req_addr(req_addr), .req_wdata(req_wdata));

    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt

    task automatic check(input logic [DATA_W:0] got, input logic [DATA_W:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic acc(input logic s, input logic w, input logic [ADDR_W-1:0] ad,
                       input logic [DATA_W-1:0] wd, input logic e, input logic [DATA_W-1:0] rd);
        exp_q.push_back({e, rd});
        m.access(s, w, ad, wd);
    endtask : acc

    task automatic tdone(input string n);
        $display("test %s done", n);
    endtask : tdone

    task automatic final_report;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // answers are matched to the oldest outstanding note
    always @(negedge ref_clk) begin
        if (rst_n === 1'h1 && rsp_valid === 1'h1) begin
            if (exp_q.size() == 0)
                check({rsp_err, rsp_rdata}, ~{rsp_err, rsp_rdata});
            else
                check({rsp_err, rsp_rdata}, exp_q.pop_front());
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        rst_n = 1'h0;
        lfsr = 32'h4EDA;
        repeat (8) @(negedge ref_clk);
        rst_n = 1'h1;
        lfsr = nxt(lfsr);
        x = lfsr;
        acc(N, W, OFS_CTRL, x, 1'h0, Z);
        acc(S, R, OFS_CTRL, Z, 1'h0, x);
        tdone("open");
        acc(S, W, OFS_KEY, x, 1'h0, Z);
        acc(N, R, OFS_KEY, Z, 1'h1, Z);
        acc(N, W, OFS_KEY, ~x, 1'h1, Z);
        acc(S, R, OFS_KEY, Z, 1'h0, x);
        tdone("secure");
        acc(S, W, OFS_CFG, x, 1'h0, Z);
        acc(N, R, OFS_CFG, Z, 1'h0, x);
        acc(N, W, OFS_CFG, ~x, 1'h1, Z);
        acc(S, R, OFS_CFG, Z, 1'h0, x);
        lfsr = nxt(lfsr);
        a = lfsr & 32'h7FFF_FFFF;
        acc(S, W, OFS_ATTR, a, 1'h0, Z);
        acc(N, R, OFS_ATTR, Z, 1'h0, a);
        acc(N, W, OFS_ATTR, ~a, 1'h1, Z);
        tdone("write_secure");
        lfsr = nxt(lfsr);
        d = lfsr;
        acc(S, W, OFS_OUT, x, 1'h0, Z);
        acc(N, W, OFS_OUT, d, 1'h0, Z);
        x = (x & ~a) | (d & a);
        acc(N, R, OFS_OUT, Z, 1'h0, x & a);
        acc(S, R, OFS_OUT, Z, 1'h0, x);
        check({1'h0, pin_out}, {1'h0, x});
        tdone("mixed");
        acc(N, W, OFS_NVCMD, d, 1'h1, Z);
        acc(S, W, OFS_NVCMD, x, 1'h0, Z);
        acc(N, R, OFS_NVCMD, Z, 1'h0, x);
        a[NVM_WEN_BIT] = 1'h1;
        acc(S, W, OFS_ATTR, a, 1'h0, Z);
        acc(N, W, OFS_NVCMD, d, 1'h0, Z);
        acc(S, R, OFS_NVCMD, Z, 1'h0, d);
        acc(N, R, 8'hFC, Z, 1'h1, Z);
        tdone("write_mixed");
        // prime the watch copy before enabling, so no stale flag fires
        acc(N, W, OFS_WATCH, a, 1'h0, Z);
        acc(N, W, OFS_WIEN, 32'h1, 1'h0, Z);
        repeat (3) @(negedge ref_clk);
        check({32'h0, watch_irq}, 33'h0);
        acc(S, W, OFS_ATTR, a ^ 32'h1, 1'h0, Z);
        repeat (3) @(negedge ref_clk);
        check({32'h0, watch_irq}, 33'h1);
        acc(N, R, OFS_WFLAG, Z, 1'h0, 32'h1);
        acc(N, W, OFS_WATCH, a ^ 32'h1, 1'h0, Z);
        acc(N, W, OFS_WFLAG, 32'h1, 1'h0, Z);
        repeat (3) @(negedge ref_clk);
        check({32'h0, watch_irq}, 33'h0);
        acc(N, R, OFS_WFLAG, Z, 1'h0, Z);
        tdone("watch");
        check({1'h0, 32'(exp_q.size())}, 33'h0);
        final_report();
    end
endmodule : tb
